// ---- rtl/wwdt_top.sv ----
/*
  Window watchdog timer with APB register access, sticky event status,
  masked interrupt and a reset request toward the system reset logic.
  Assumes the instruction strobes are one-cycle pulses synchronous to
  core_clk_i and that the APB master follows the standard two-phase protocol.
*/
// Local design decisions: the APB slave port and the register offsets.
module wwdt_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        wakeup_clk_i,
  input  wire logic        app_reset_done_i,
  input  wire logic        watchdog_service_i,
  input  wire logic        watchdog_disable_instr_i,
  input  wire logic        watchdog_enable_instr_i,
  output logic             reset_req_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [wwdt_pkg::CTRL_W-1:0] ctrl;
    logic [wwdt_pkg::CNT_W-1:0]  reload;
    logic [wwdt_pkg::CNT_W-1:0]  window;
    logic [wwdt_pkg::CNT_W-1:0]  count;
    logic                        enabled;
    logic [wwdt_pkg::EVT_W-1:0]  status;
    logic [wwdt_pkg::EVT_W-1:0]  mask;
    logic [wwdt_pkg::DATA_W-1:0] prdata;
    logic                        pslverr;
    logic                        reset_req;
  } wwdt_top_state_t;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_RELOAD,
    SEL_WINDOW,
    SEL_COUNT,
    SEL_STATUS,
    SEL_MASK,
    SEL_NONE
  } wwdt_sel_t;

  wwdt_top_state_t            st_ff;
  wwdt_top_state_t            nxt_st;
  logic [1:0]                 rst_sync_ff;
  logic                       rst_sync_n;
  logic                       wu_rise;
  logic                       pre_src;
  logic                       tick;
  logic                       apb_setup;
  logic                       apb_write;
  logic                       ovf_evt;
  logic                       win_evt;
  logic [wwdt_pkg::EVT_W-1:0] evt_clr;
  wwdt_sel_t                  sel;

  function automatic wwdt_sel_t reg_decode(input logic [11:0] addr);
    case (addr)
      wwdt_pkg::ADDR_CTRL:   reg_decode = SEL_CTRL;
      wwdt_pkg::ADDR_RELOAD: reg_decode = SEL_RELOAD;
      wwdt_pkg::ADDR_WINDOW: reg_decode = SEL_WINDOW;
      wwdt_pkg::ADDR_COUNT:  reg_decode = SEL_COUNT;
      wwdt_pkg::ADDR_STATUS: reg_decode = SEL_STATUS;
      wwdt_pkg::ADDR_MASK:   reg_decode = SEL_MASK;
      default:               reg_decode = SEL_NONE;
    endcase
  endfunction

  // Servicing is forbidden while the count is still below the boundary.
  function automatic logic in_forbidden(input logic [15:0] cnt, input logic [15:0] bound);
    in_forbidden = cnt < bound;
  endfunction

  // The reset is released through two flops so its removal is clean.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_ff[1];

  wwdt_edge_sync u_wu_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_sync_n),
    .async_i    (wakeup_clk_i),
    .rise_o     (wu_rise)
  );

  // Source select: every core cycle, or once per rising wake-up clock edge.
  assign pre_src = st_ff.ctrl[wwdt_pkg::CTRL_SRC_BIT] ? wu_rise : 1'b1;

  wwdt_prescaler u_prescaler (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_sync_n),
    .src_i       (pre_src),
    .div_short_i (st_ff.ctrl[wwdt_pkg::CTRL_DIV_BIT]),
    .clear_i     (app_reset_done_i),
    .tick_o      (tick)
  );

  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pwrite_i;
  assign sel       = reg_decode(paddr_i);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.reset_req = 1'b0;
    ovf_evt          = 1'b0;
    win_evt          = 1'b0;
    evt_clr          = '0;

    // Register writes take effect at the access-phase edge.
    if (apb_write) begin
      case (sel)
        SEL_CTRL:   nxt_st.ctrl   = pwdata_i[wwdt_pkg::CTRL_W-1:0];
        SEL_RELOAD: nxt_st.reload = pwdata_i[wwdt_pkg::CNT_W-1:0];
        SEL_WINDOW: nxt_st.window = pwdata_i[wwdt_pkg::CNT_W-1:0];
        SEL_STATUS: evt_clr       = pwdata_i[wwdt_pkg::EVT_W-1:0];
        SEL_MASK:   nxt_st.mask   = pwdata_i[wwdt_pkg::EVT_W-1:0];
        default:    nxt_st.mask   = st_ff.mask;
      endcase
    end

    // Read data is captured in the setup phase and presented in the access phase.
    if (apb_setup) begin
      nxt_st.prdata  = '0;
      nxt_st.pslverr = 1'b0;
      case (sel)
        SEL_CTRL:   nxt_st.prdata[wwdt_pkg::CTRL_W-1:0] = st_ff.ctrl;
        SEL_RELOAD: nxt_st.prdata[wwdt_pkg::CNT_W-1:0]  = st_ff.reload;
        SEL_WINDOW: nxt_st.prdata[wwdt_pkg::CNT_W-1:0]  = st_ff.window;
        SEL_COUNT: begin
          nxt_st.prdata[wwdt_pkg::CNT_W-1:0]        = st_ff.count;
          nxt_st.prdata[wwdt_pkg::COUNT_EN_BIT]     = st_ff.enabled;
        end
        SEL_STATUS: nxt_st.prdata[wwdt_pkg::EVT_W-1:0]  = st_ff.status;
        SEL_MASK:   nxt_st.prdata[wwdt_pkg::EVT_W-1:0]  = st_ff.mask;
        default:    nxt_st.pslverr = 1'b1;
      endcase
    end

    // Counter and enable; an application reset outranks every instruction.
    if (app_reset_done_i) begin
      nxt_st.enabled = 1'b1;
      nxt_st.count   = st_ff.reload;
    end else begin
      if (watchdog_disable_instr_i) begin
        nxt_st.enabled = 1'b0;
      end else if (watchdog_enable_instr_i) begin
        nxt_st.enabled = 1'b1;
      end
      if (watchdog_service_i) begin
        // A service while stopped still reloads but cannot violate the window.
        win_evt      = st_ff.enabled & in_forbidden(st_ff.count, st_ff.window);
        nxt_st.count = st_ff.reload;
      end else if (st_ff.enabled && tick) begin
        nxt_st.count = st_ff.count + 16'h0001;
        ovf_evt      = (st_ff.count == wwdt_pkg::CNT_MAX);
      end
    end

    // A new event wins over a clear written in the same cycle.
    nxt_st.status = (st_ff.status & ~evt_clr)
                  | {win_evt, ovf_evt};
    nxt_st.reset_req = ovf_evt | win_evt;
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff.ctrl      <= wwdt_pkg::CTRL_RST;
      st_ff.reload    <= wwdt_pkg::RELOAD_RST;
      st_ff.window    <= wwdt_pkg::WINDOW_RST;
      st_ff.count     <= wwdt_pkg::RELOAD_RST;
      st_ff.enabled   <= 1'b1;
      st_ff.status    <= wwdt_pkg::EVT_RST;
      st_ff.mask      <= wwdt_pkg::EVT_RST;
      st_ff.prdata    <= '0;
      st_ff.pslverr   <= 1'b0;
      st_ff.reset_req <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o    = st_ff.prdata;
  assign pslverr_o   = st_ff.pslverr;
  assign pready_o    = psel_i & penable_i;
  assign reset_req_o = st_ff.reset_req;
  assign irq_o       = |(st_ff.status & st_ff.mask);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_sync_n);

  chk_app_reset_enables: assert property (
    app_reset_done_i |=> st_ff.enabled && (st_ff.count == $past(st_ff.reload)))
    else $error("Application reset did not enable and reload the watchdog.");

  chk_disable_stops_count: assert property (
    (watchdog_disable_instr_i && !app_reset_done_i && !watchdog_service_i)
      |=> !st_ff.enabled ##1 (st_ff.count == $past(st_ff.count) || !$stable(st_ff.enabled)
          || $past(watchdog_service_i) || $past(app_reset_done_i)))
    else $error("Disabled watchdog kept counting.");

  chk_enable_restarts: assert property (
    (watchdog_enable_instr_i && !watchdog_disable_instr_i) |=> st_ff.enabled)
    else $error("Enable instruction did not start the watchdog.");

  chk_overflow_request: assert property (
    (st_ff.enabled && tick && st_ff.count == wwdt_pkg::CNT_MAX
      && !watchdog_service_i && !app_reset_done_i)
      |=> reset_req_o && st_ff.status[wwdt_pkg::EVT_OVF_BIT] && st_ff.count == 16'h0000
          ##1 (!reset_req_o || $past(win_evt)))
    else $error("Overflow did not raise a reset request.");

  chk_window_violation: assert property (
    (watchdog_service_i && st_ff.enabled && !app_reset_done_i
      && st_ff.count < st_ff.window)
      |=> reset_req_o && st_ff.status[wwdt_pkg::EVT_WIN_BIT])
    else $error("Service inside the forbidden window went unreported.");

  chk_open_window_quiet: assert property (
    (watchdog_service_i && !app_reset_done_i && st_ff.count >= st_ff.window)
      |=> !reset_req_o)
    else $error("Service in the open window raised a reset request.");

  chk_service_reload: assert property (
    (watchdog_service_i && !app_reset_done_i) |=> st_ff.count == $past(st_ff.reload))
    else $error("Service did not reload the counter.");

  chk_tick_spacing: assert property (
    (tick && !st_ff.ctrl[wwdt_pkg::CTRL_SRC_BIT] && st_ff.ctrl[wwdt_pkg::CTRL_DIV_BIT]
      && !apb_write && !app_reset_done_i) |=> !tick [*8])
    else $error("Prescaled ticks came too close together.");

  chk_power_up_defaults: assert property (
    !$past(rst_sync_n) |-> st_ff.ctrl == wwdt_pkg::CTRL_RST
      && st_ff.reload == wwdt_pkg::RELOAD_RST && st_ff.enabled)
    else $error("Power-up defaults are wrong.");

  chk_count_step: assert property (
    (st_ff.enabled && tick && !watchdog_service_i && !app_reset_done_i)
      |=> st_ff.count == 16'($past(st_ff.count) + 16'h0001))
    else $error("Counter did not step by one on a tick.");

  chk_irq_masking: assert property (
    (st_ff.status & st_ff.mask) == 2'h0 |-> !irq_o)
    else $error("Interrupt raised with no unmasked status bit.");

  chk_irq_on_event: assert property (
    (ovf_evt && st_ff.mask[wwdt_pkg::EVT_OVF_BIT] && !apb_write) |=> irq_o)
    else $error("Unmasked overflow did not raise the interrupt.");

  chk_unmapped_refused: assert property (
    (apb_setup && sel == SEL_NONE) |=> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("Unmapped access was not refused.");

  chk_mapped_no_error: assert property (
    (apb_setup && sel != SEL_NONE) |=> !pslverr_o)
    else $error("Mapped access reported an error.");

  // The master may take read data late in the access phase, so it must not move before then.
  chk_read_data_holds: assert property (
    !apb_setup |=> $stable(prdata_o) && $stable(pslverr_o))
    else $error("Read data changed outside a setup phase.");

  chk_reload_read: assert property (
    (apb_setup && sel == SEL_RELOAD) |=> prdata_o == {16'h0000, $past(st_ff.reload)})
    else $error("Reload value read back wrong.");

  chk_count_read_only: assert property (
    (apb_write && sel == SEL_COUNT && !app_reset_done_i && !watchdog_service_i && !tick)
      |=> st_ff.count == $past(st_ff.count))
    else $error("A write changed the read-only counter.");

  chk_unmapped_write_ignored: assert property (
    (apb_write && sel == SEL_NONE)
      |=> $stable(st_ff.ctrl) && $stable(st_ff.reload) && $stable(st_ff.window)
          && $stable(st_ff.mask))
    else $error("A write to an unmapped address changed a register.");

  // A clear written in the same cycle as the event must not lose the event.
  chk_ovf_flag_sets: assert property (
    ovf_evt |=> st_ff.status[wwdt_pkg::EVT_OVF_BIT])
    else $error("Overflow flag was not set.");

  chk_win_flag_sets: assert property (
    win_evt |=> st_ff.status[wwdt_pkg::EVT_WIN_BIT])
    else $error("Window violation flag was not set.");

  chk_status_w1c: assert property (
    (apb_write && sel == SEL_STATUS && pwdata_i[wwdt_pkg::EVT_OVF_BIT] && !ovf_evt)
      |=> !st_ff.status[wwdt_pkg::EVT_OVF_BIT])
    else $error("Writing one did not clear the overflow flag.");

  chk_req_has_cause: assert property (
    reset_req_o |-> $past(ovf_evt || win_evt))
    else $error("Reset request raised without an event.");

  chk_stopped_service_quiet: assert property (
    (watchdog_service_i && !st_ff.enabled) |-> !win_evt)
    else $error("Service of a stopped watchdog raised a violation.");

  chk_prescaler_clear: assert property (
    app_reset_done_i |-> !tick ##1 !tick)
    else $error("Prescaler ticked right after an application reset.");

  chk_disabled_no_overflow: assert property (
    !st_ff.enabled |-> !ovf_evt)
    else $error("A stopped watchdog overflowed.");

  chk_stopped_count_holds: assert property (
    (!st_ff.enabled && !watchdog_service_i && !app_reset_done_i)
      |=> st_ff.count == $past(st_ff.count))
    else $error("A stopped watchdog kept counting.");

endmodule

// ---- rtl/wwdt_pkg.sv ----
/*
  Constants shared by the window watchdog: register map, field positions,
  reset values and prescaler limits.
  Assumes a 25 MHz core clock and a 500 kHz wake-up clock sampled by it.
*/
// Overview of operation
// - An application reset always leaves the watchdog enabled and counting.
// - Disable and enable instructions stop or restart the watchdog, except in a cycle with an application reset.
// - An unserviced overflow of the enabled counter raises a reset request.
// - A programmable window boundary forbids servicing during part of the count.
// - Servicing the enabled watchdog inside the forbidden window raises a reset request like an overflow.
// - Sixteen-bit counter, system or wake-up clock, divided by 16384 or 256.
// - Every service loads the counter from the software reload value.
// - Power-up defaults give about 0.13 s timeout from the 500 kHz wake-up clock.
package wwdt_pkg;

  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 14;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Prescaler limits: tick when the masked prescaler bits are all ones.
  localparam logic [13:0] DIV_LONG_LIM  = 14'h3FFF;
  localparam logic [13:0] DIV_SHORT_LIM = 14'h00FF;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // Default timeout figures, each in its own unit.
  localparam int unsigned WU_CLK_KHZ      = 500;
  localparam int unsigned DFLT_TIMEOUT_US = 130000;
  localparam int unsigned DFLT_DIV        = 16384;
  localparam int unsigned US_PER_MS       = 1000;
  localparam int unsigned DFLT_TICKS      =
    (DFLT_TIMEOUT_US * WU_CLK_KHZ / US_PER_MS + DFLT_DIV / 2) / DFLT_DIV;
  localparam int unsigned CNT_MOD         = 32'h0001_0000;
  localparam logic [15:0] RELOAD_RST      = 16'(CNT_MOD - DFLT_TICKS);
  localparam logic [15:0] WINDOW_RST      = 16'h0000;

  // Register byte offsets.
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_RELOAD = 12'h004;
  localparam logic [11:0] ADDR_WINDOW = 12'h008;
  localparam logic [11:0] ADDR_COUNT  = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_MASK   = 12'h014;

  // Control fields: source 1 selects the wake-up clock, divider 1 selects 256.
  localparam int unsigned CTRL_W          = 2;
  localparam int unsigned CTRL_SRC_BIT    = 0;
  localparam int unsigned CTRL_DIV_BIT    = 1;
  localparam logic [1:0]  CTRL_RST        = 2'h1;
  localparam int unsigned COUNT_EN_BIT    = 16;

  // Status and mask fields.
  localparam int unsigned EVT_W           = 2;
  localparam int unsigned EVT_OVF_BIT     = 0;
  localparam int unsigned EVT_WIN_BIT     = 1;
  localparam logic [1:0]  EVT_RST         = 2'h0;

endpackage

// ---- rtl/wwdt_edge_sync.sv ----
/*
  Two-stage synchroniser with rising-edge detection for the wake-up clock.
  Assumes the sampled clock is much slower than the core clock.
*/
module wwdt_edge_sync (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      rise_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } wwdt_sync_state_t;

  wwdt_sync_state_t st_ff;
  wwdt_sync_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = async_i;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise_o = st_ff.sync & ~st_ff.prev;

endmodule

// ---- rtl/wwdt_prescaler.sv ----
/*
  Prescaler of the watchdog: counts source pulses and emits one tick per
  16384 or 256 of them.
  Assumes src_i is a one-cycle enable pulse or held high for the core clock.
*/
module wwdt_prescaler (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic src_i,
  input  wire logic div_short_i,
  input  wire logic clear_i,
  output logic      tick_o
);

  typedef struct packed {
    logic [wwdt_pkg::PRE_W-1:0] cnt;
  } wwdt_pre_state_t;

  wwdt_pre_state_t            st_ff;
  wwdt_pre_state_t            nxt_st;
  logic [wwdt_pkg::PRE_W-1:0] lim;

  assign lim    = div_short_i ? wwdt_pkg::DIV_SHORT_LIM : wwdt_pkg::DIV_LONG_LIM;
  assign tick_o = src_i & ~clear_i & ((st_ff.cnt & lim) == lim);

  always_comb begin
    nxt_st = st_ff;
    if (clear_i) begin
      nxt_st.cnt = '0;
    end else if (src_i) begin
      nxt_st.cnt = st_ff.cnt + 14'h0001;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ---- dv/wwdt_cpu_model.sv ----
/*
  Behavioural model of the processor that issues the watchdog instructions
  and of the system reset logic that receives the reset request.
  Assumes one core clock; strobes are one-cycle pulses that change just
  after a rising edge and rest low between instructions.
*/
module wwdt_cpu_model (
  input  wire logic clk_i,
  input  wire logic reset_req_i,
  output logic      service_o,
  output logic      disable_o,
  output logic      enable_o,
  output logic      app_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned req_cnt = 0;

  initial begin
    {service_o, disable_o, enable_o, app_done_o} = 4'h0;
  end

  // The reset logic counts every request; the bench judges when they come.
  always @(posedge clk_i) begin
    if (reset_req_i === 1'b1) begin
      req_cnt <= req_cnt + 1;
    end
  end

  // Kind 0 is a service, 1 disable, 2 enable, anything else app reset done.
  task automatic pulse(input int kind);
    @(posedge clk_i);
    case (kind)
      0: service_o <= 1'b1;
      1: disable_o <= 1'b1;
      2: enable_o <= 1'b1;
      default: app_done_o <= 1'b1;
    endcase
    @(posedge clk_i);
    {service_o, disable_o, enable_o, app_done_o} <= 4'h0;
  endtask
endmodule

// ---- dv/window_watchdog_timer_bench.sv ----
/*
  Self-checking bench of the window watchdog: APB master, instruction
  model, register, timing, window and interrupt scenarios.
  Assumes the register map and latencies given with the design.
*/
module window_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst_n;
  logic        wu_clk;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr, reset_req, irq, svc, dis, ena, app;
  int          err_total    = 0;
  int          total_checks = 0;
  int          n;

  always #20 core_clk = ~core_clk;
  always #1000 wu_clk = ~wu_clk;

  wwdt_top u_wwdt_top (.core_clk_i(core_clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .wakeup_clk_i(wu_clk),
    .app_reset_done_i(app), .watchdog_service_i(svc), .watchdog_disable_instr_i(dis),
    .watchdog_enable_instr_i(ena), .reset_req_o(reset_req), .irq_o(irq));

  wwdt_cpu_model u_wwdt_cpu_model (.clk_i(core_clk), .reset_req_i(reset_req),
    .service_o(svc), .disable_o(dis), .enable_o(ena), .app_done_o(app));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask

  // Counts cycles until the reset logic sees a new request, at most lim.
  task automatic wait_req(input int lim, output int cyc);
    int unsigned c0;
    c0 = u_wwdt_cpu_model.req_cnt;
    cyc = 0;
    while (u_wwdt_cpu_model.req_cnt == c0 && cyc < lim) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
  endtask

  // Restarting from app reset clears the prescaler, so tick phases are known.
  task automatic restart(input logic [31:0] rel);
    wr(wwdt_pkg::ADDR_RELOAD, rel);
    u_wwdt_cpu_model.pulse(3);
    u_wwdt_cpu_model.pulse(0);
  endtask

  task automatic t_reset;
    rdc(wwdt_pkg::ADDR_CTRL, 32'h1, "ctrl");
    rdc(wwdt_pkg::ADDR_RELOAD, 32'hFFFC, "reload");
    rdc(wwdt_pkg::ADDR_WINDOW, 32'h0, "window");
    rdc(wwdt_pkg::ADDR_COUNT, 32'h0001_FFFC, "count");
    rdc(wwdt_pkg::ADDR_STATUS, 32'h0, "status");
    rdc(wwdt_pkg::ADDR_MASK, 32'h0, "mask");
  endtask

  task automatic t_unmapped;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    @(posedge core_clk);
    chk("pready idle", 32'h0, {31'h0, pready});
  endtask

  task automatic t_reload;
    wr(wwdt_pkg::ADDR_CTRL, 32'h2);
    restart(32'hFFF0);
    rdc(wwdt_pkg::ADDR_COUNT, 32'h0001_FFF0, "count after service");
  endtask

  task automatic t_rate;
    restart(32'hFFFF);
    wait_req(400, n);
    chk("short tick", 32'h1, {31'h0, n > 240 && n < 270});
    wr(wwdt_pkg::ADDR_CTRL, 32'h0);
    restart(32'hFFFF);
    wait_req(17000, n);
    chk("long tick", 32'h1, {31'h0, n > 16370 && n < 16400});
    rdc(wwdt_pkg::ADDR_COUNT, 32'h0001_0000, "count wrapped");
    rdc(wwdt_pkg::ADDR_STATUS, 32'h1, "overflow flag");
  endtask

  // Wake-up source at the short divider: one tick per 256 wake-up edges of 50 cycles.
  task automatic t_wakeup;
    wr(wwdt_pkg::ADDR_CTRL, 32'h3);
    restart(32'hFFFF);
    wait_req(13500, n);
    chk("wake-up tick", 32'h1, {31'h0, n > 12700 && n < 12900});
  endtask

  task automatic t_irq;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(wwdt_pkg::ADDR_MASK, 32'h3);
    @(posedge core_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(wwdt_pkg::ADDR_STATUS, 32'h1);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc(wwdt_pkg::ADDR_STATUS, 32'h0, "status cleared");
  endtask

  task automatic t_disable;
    wr(wwdt_pkg::ADDR_CTRL, 32'h2);
    restart(32'hFFFF);
    u_wwdt_cpu_model.pulse(1);
    wait_req(700, n);
    chk("no req disabled", 32'd700, n);
    rdc(wwdt_pkg::ADDR_COUNT, 32'h0000_FFFF, "count held");
    u_wwdt_cpu_model.pulse(2);
    wait_req(300, n);
    chk("req after enable", 32'h1, {31'h0, n < 300});
    u_wwdt_cpu_model.pulse(1);
    u_wwdt_cpu_model.pulse(3);
    rdc(wwdt_pkg::ADDR_COUNT, 32'h0001_FFFF, "forced enable");
  endtask

  task automatic t_window;
    int unsigned c;
    wr(wwdt_pkg::ADDR_CTRL, 32'h0);
    wr(wwdt_pkg::ADDR_STATUS, 32'h3);
    restart(32'hFFF8);
    wr(wwdt_pkg::ADDR_WINDOW, 32'hFFF8);
    wr(wwdt_pkg::ADDR_RELOAD, 32'hFFF7);
    u_wwdt_cpu_model.pulse(0);
    wait_req(4, n);
    chk("boundary service", 32'd4, n);
    u_wwdt_cpu_model.pulse(0);
    wait_req(4, n);
    chk("window violation", 32'h1, {31'h0, n < 4});
    c = u_wwdt_cpu_model.req_cnt;
    repeat (3) @(posedge core_clk);
    chk("single request", c, u_wwdt_cpu_model.req_cnt);
    rdc(wwdt_pkg::ADDR_STATUS, 32'h2, "violation flag");
    chk("irq violation", 32'h1, {31'h0, irq});
  endtask

  task automatic end_sim;
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n    = 1'b0;
    wu_clk   = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_unmapped();
    t_reload();
    t_rate();
    t_wakeup();
    t_irq();
    t_disable();
    t_window();
    end_sim();
  end

  initial begin
    #(60000 * 40);
    err_total++;
    end_sim();
  end
endmodule
